// ==== core/sensor_serial_port.sv ====
// Two-wire register port of the sensor with configuration and power-down.
// Assumes the host drives the serial clock; data pin resolved outside.
`timescale 1ns/100ps
`default_nettype none

module sensor_serial_port
    import serial_port_pkg::*;
(
    input wire logic clock,               // 20 MHz system clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic clk_en,              // Clock enable, freezes state when low
    input wire logic serial_clock,        // Serial clock pin from host
    input wire logic data_in,             // Data pin input
    output logic data_out,                // Data pin output value
    output logic data_oe,                 // Data pin output enable
    input wire logic shutter_drive,       // Shutter level from imaging logic
    output logic light_source_shutter_out, // Light-source control output value
    output logic light_source_oe,         // Light-source output enable
    output logic power_down,              // Power-down state
    output logic soft_reset,              // One-cycle soft reset pulse
    output logic [7:0] config_value       // Configuration register contents
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    edge_sync_if sck_s ();
    edge_sync_if sdi_s ();

    pin_sync u_sck_sync (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(serial_clock),
        .sync(sck_s)
    );

    pin_sync u_sdi_sync (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(data_in),
        .sync(sdi_s)
    );

    // ****************************************
    // Shift and phase control
    // ****************************************
    phase_t phase_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [6:0] addr_r;
    logic [7:0] config_r;
    logic [7:0] tx_r;
    logic drive_r;
    logic data_out_r;
    logic active_r;
    logic [TIMEOUT_W-1:0] timer_r;
    logic timeout;
    logic soft_reset_r;
    logic [7:0] shift_nxt;
    logic write_done;
    logic [7:0] config_nxt;
    logic addr_done;
    logic read_done;
    logic cfg_write;
    logic shutter_r;

    assign shift_nxt = {shift_r[6:0], sdi_s.level};
    // The timer stops in power-down, so a cut command there is never recovered
    assign timeout = clk_en && active_r && !config_r[BIT_POWER_DOWN]
        && (timer_r >= TIMEOUT_W'(TIMEOUT_CYCLES));
    assign write_done = sck_s.rise && (phase_r == PH_WDATA)
        && (bit_cnt_r == BIT_COUNT_LAST);
    assign addr_done = sck_s.rise && (phase_r == PH_ADDR)
        && (bit_cnt_r == BIT_COUNT_ADDR_LAST);
    assign read_done = sck_s.rise && (phase_r == PH_RDATA)
        && (bit_cnt_r == BIT_COUNT_LAST);
    assign cfg_write = write_done && (addr_r == ADDR_CONFIG);

    always_ff @(posedge clock) begin
        if (rst || timeout) begin
            phase_r <= PH_ADDR;
            bit_cnt_r <= BIT_COUNT_ZERO;
            shift_r <= ZERO_BYTE;
            addr_r <= ADDR_CONFIG;
        end else if (clk_en && sck_s.rise) begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            case (phase_r)
                PH_ADDR: begin
                    if (bit_cnt_r == BIT_COUNT_ADDR_LAST) begin
                        addr_r <= shift_nxt[6:0];
                        phase_r <= shift_nxt[7] ? PH_WDATA : PH_RDATA;
                    end
                end
                PH_WDATA: begin
                    if (bit_cnt_r == BIT_COUNT_LAST) begin
                        phase_r <= PH_ADDR;
                    end
                end
                PH_RDATA: begin
                    if (bit_cnt_r == BIT_COUNT_LAST) begin
                        phase_r <= PH_HOLD;
                    end
                end
                PH_HOLD: begin
                    phase_r <= PH_ADDR;
                end
                default: begin
                    phase_r <= PH_ADDR;
                end
            endcase
            // The rise after a read's final bit is the first bit of the next command
            if (phase_r == PH_HOLD) begin
                bit_cnt_r <= 4'h1;
                shift_r <= {7'h00, sdi_s.level};
            end
        end
    end

    // ****************************************
    // Transaction timer
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst || timeout) begin
            active_r <= 1'b0;
            timer_r <= '0;
        end else if (clk_en) begin
            if (write_done || read_done) begin
                active_r <= 1'b0;
                timer_r <= '0;
            end else if (!active_r && (sck_s.rise || sck_s.fall)) begin
                active_r <= 1'b1;
                timer_r <= '0;
            end else if (active_r && !config_r[BIT_POWER_DOWN]) begin
                timer_r <= timer_r + TIMEOUT_W'(1);
            end
        end
    end

    // ****************************************
    // Configuration register
    // ****************************************
    always_comb begin
        config_nxt = shift_nxt;
        if (config_r[BIT_POWER_DOWN]) begin
            config_nxt = config_r;
            config_nxt[BIT_POWER_DOWN] = shift_nxt[BIT_POWER_DOWN];
        end
        config_nxt[BIT_RESET] = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            config_r <= CONFIG_RESET_VAL;
            soft_reset_r <= 1'b0;
        end else if (clk_en) begin
            soft_reset_r <= 1'b0;
            if (cfg_write) begin
                config_r <= config_nxt;
                soft_reset_r <= shift_nxt[BIT_RESET] && !config_r[BIT_POWER_DOWN];
            end
        end
    end

    // ****************************************
    // Read data and pin drive
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_r <= ZERO_BYTE;
        end else if (clk_en && addr_done) begin
            tx_r <= (shift_nxt[6:0] == ADDR_CONFIG) ? config_r : ZERO_BYTE;
        end else if (clk_en && sck_s.fall && phase_r == PH_RDATA) begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (rst || timeout) begin
            drive_r <= 1'b0;
            data_out_r <= 1'b0;
        end else if (clk_en) begin
            // Entering power-down releases the pin even where a read left it driven
            if (config_r[BIT_POWER_DOWN] || (cfg_write && shift_nxt[BIT_POWER_DOWN])) begin
                drive_r <= 1'b0;
            end else if (sck_s.fall && phase_r == PH_RDATA) begin
                drive_r <= 1'b1;
                data_out_r <= tx_r[7];
            end else if (sck_s.fall && phase_r == PH_HOLD) begin
                drive_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Light-source output
    // ****************************************
    // Registered so no combinational path runs from the imaging logic to the pin
    always_ff @(posedge clock) begin
        if (rst) begin
            shutter_r <= 1'b0;
        end else if (clk_en) begin
            shutter_r <= shutter_drive;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_out = data_out_r;
    assign data_oe = drive_r && !config_r[BIT_POWER_DOWN];
    assign light_source_shutter_out = shutter_r;
    assign light_source_oe = !config_r[BIT_POWER_DOWN];
    assign power_down = config_r[BIT_POWER_DOWN];
    assign soft_reset = soft_reset_r;
    assign config_value = config_r;
endmodule

`default_nettype wire

// ==== core/serial_port_pkg.sv ====
// Constants, types and register layout of the two-wire sensor register port.
// Assumes a 20 MHz system clock; serial clock and data arrive asynchronously.

package serial_port_pkg;

    localparam int unsigned CLOCK_HZ = 20_000_000;
    localparam int unsigned TIMEOUT_MS = 90;
    localparam int unsigned TIMEOUT_CYCLES = CLOCK_HZ / 1000 * TIMEOUT_MS;
    localparam int unsigned TIMEOUT_W = 22;

    localparam logic [6:0] ADDR_CONFIG = 7'h00;
    localparam logic [7:0] CONFIG_RESET_VAL = 8'h00;
    localparam int unsigned BIT_RESET = 7;
    localparam int unsigned BIT_POWER_DOWN = 6;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    localparam logic [3:0] BIT_COUNT_ADDR_LAST = 4'h7;
    localparam logic [3:0] BIT_COUNT_LAST = 4'hf;
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_WDATA = 2'b01,
        PH_RDATA = 2'b11,
        PH_HOLD = 2'b10
    } phase_t;

endpackage

// ==== core/edge_sync_if.sv ====
// Carries a synchronised pin level and its edge strobes between modules.
// Assumes one clock domain on both sides.
`timescale 1ns/100ps
`default_nettype none

interface edge_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport source (output level, rise, fall);
    modport sink (input level, rise, fall);
endinterface

`default_nettype wire

// ==== core/pin_sync.sv ====
// Two-flop synchroniser with edge detect on the third stage.
// Assumes an asynchronous pin input and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input wire logic clock,          // System clock
    input wire logic rst,            // Synchronous reset
    input wire logic clk_en,         // Clock enable
    input wire logic pin,            // Asynchronous pin
    edge_sync_if.source sync         // Level and edges
);
    logic meta_r;
    logic stable_r;
    logic prev_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= 1'b1;
            stable_r <= 1'b1;
            prev_r <= 1'b1;
        end else if (clk_en) begin
            meta_r <= pin;
            stable_r <= meta_r;
            prev_r <= stable_r;
        end
    end

    assign sync.level = stable_r;
    assign sync.rise = clk_en & stable_r & ~prev_r;
    assign sync.fall = clk_en & ~stable_r & prev_r;
endmodule

`default_nettype wire

// ==== verif/port_monitor.sv ====
// Checker on the register port's top-level ports.
// Assumes serial clock edges land on system clock edges.
`timescale 1ns/100ps
`default_nettype none
module port_monitor (
    input wire logic clock, // System clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Enable
    input wire logic serial_clock, // Serial clock
    input wire logic data_in, // Data pin
    input wire logic data_out, // Data value
    input wire logic data_oe, // Data enable
    input wire logic shutter_drive, // Shutter in
    input wire logic light_source_shutter_out, // Shutter out
    input wire logic light_source_oe, // Light enable
    input wire logic power_down, // Power-down
    input wire logic soft_reset, // Reset pulse
    input wire logic [7:0] config_value // Configuration
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_oe_pd; power_down |-> !data_oe && !light_source_oe; endproperty
    a_oe_pd: assert property (p_oe_pd) else $error("pins driven in power-down");
    property p_ls_on; !power_down |-> light_source_oe; endproperty
    a_ls_on: assert property (p_ls_on) else $error("light output off while awake");
    property p_pd_bit; power_down == config_value[6]; endproperty
    a_pd_bit: assert property (p_pd_bit) else $error("power-down differs from bit 6");
    property p_bit7; config_value[7] == 1'b0; endproperty
    a_bit7: assert property (p_bit7) else $error("reset bit kept");
    property p_sr; soft_reset |=> !soft_reset; endproperty
    a_sr: assert property (p_sr) else $error("soft reset pulse too long");
    property p_keep; power_down && $past(power_down) |-> config_value[5:0] == $past(config_value[5:0]); endproperty
    a_keep: assert property (p_keep) else $error("setting changed in power-down");
    property p_dchg; data_oe && $changed(data_out) |-> !$past(serial_clock, 3); endproperty
    a_dchg: assert property (p_dchg) else $error("data moved off falling edge");
    property p_start; $rose(data_oe) |-> !$past(serial_clock, 3); endproperty
    a_start: assert property (p_start) else $error("drive without host clock");
    property p_pd_edge; $changed(power_down) |-> $past(serial_clock, 3); endproperty
    a_pd_edge: assert property (p_pd_edge) else $error("power-down moved off a write");
    c_pd: cover property ($rose(power_down));
    c_sr: cover property (soft_reset);
    c_rd: cover property ($fell(data_oe));
endmodule
bind sensor_serial_port port_monitor mon_u (.clock, .rst, .clk_en, .serial_clock, .data_in, .data_out,
    .data_oe, .shutter_drive, .light_source_shutter_out, .light_source_oe, .power_down, .soft_reset,
    .config_value);
`default_nettype wire

// ==== verif/host_model.sv ====
// Host model: drives the serial clock, resolves the shared data pin.
// Assumes a 20 MHz clock; one serial bit spans eight system clocks.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clock, // System clock
    input wire logic dev_out, // Device data
    input wire logic dev_oe, // Device enable
    output var logic serial_clock, // Serial clock
    output wire logic line // Data pin level
);
    logic host_d = 1'b1;
    logic host_oe = 1'b1;
    logic last_r = 1'b1;
    initial serial_clock = 1'b1;
    // A floating pin shows a changing pattern
    assign line = dev_oe ? dev_out : host_oe ? host_d : ~last_r;
    always @(posedge clock) last_r <= line;
    task automatic xfer(input logic [15:0] w, output logic [7:0] q);
        q = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clock);
            serial_clock <= 1'b0;
            host_oe <= w[15] || i > 7;
            host_d <= w[i];
            repeat (4) @(posedge clock);
            serial_clock <= 1'b1;
            repeat (3) @(posedge clock);
            if (i < 8) q[i] = line;
            if (i == 8 && !w[15]) begin
                host_oe <= 1'b0;
                repeat (2000) @(posedge clock);
            end
        end
        repeat (w[15] ? 2000 : 8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ==== verif/test_two_wire_port_with_power_down.sv ====
// Self-checking bench of the register port against a host model.
// Assumes the host model's eight system clocks per serial bit.
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_port_with_power_down;
    import serial_port_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic shutter_drive = 1'b0;
    logic clk_en = 1'b1;
    logic shutter_prev = 1'b0;
    logic serial_clock, line, data_out, data_oe, ls_out, ls_oe, power_down, soft_reset;
    logic [7:0] config_value, cfg, v, q;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 32'h1c88;
    int pulses = 0;
    always #25 clock = ~clock;
    always @(posedge clock) shutter_drive <= 1'($random(seed));
    always @(posedge clock) if (soft_reset === 1'b1) pulses <= pulses + 1;
    // The light-source output is one register behind its source
    always @(posedge clock) shutter_prev <= shutter_drive;
    sensor_serial_port dut_u (.clock(clock), .rst(rst), .clk_en(clk_en), .serial_clock(serial_clock),
        .data_in(line), .data_out(data_out), .data_oe(data_oe), .shutter_drive(shutter_drive),
        .light_source_shutter_out(ls_out), .light_source_oe(ls_oe), .power_down(power_down),
        .soft_reset(soft_reset), .config_value(config_value));
    host_model host_u (.clock(clock), .dev_out(data_out), .dev_oe(data_oe), .serial_clock(serial_clock),
        .line(line));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Asleep, only the power-down bit takes the written value
    function automatic logic [7:0] next_cfg(input logic [7:0] cur, input logic [7:0] d);
        next_cfg = cur[6] ? {1'b0, d[6], cur[5:0]} : {1'b0, d[6:0]};
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b1, a, d}, q);
        if (a == ADDR_CONFIG) cfg = next_cfg(cfg, d);
        check("config", config_value, cfg);
        check("power_down", {7'h00, power_down}, {7'h00, cfg[6]});
        check("light_oe", {7'h00, ls_oe}, {7'h00, !cfg[6]});
        check("shutter", {7'h00, ls_out}, {7'h00, shutter_prev});
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host_u.xfer({1'b0, a, 8'h00}, q);
        check("read", q, exp);
        check("hold", {7'h00, data_oe}, 8'h01);
    endtask
    initial begin
        #4_000_000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        cfg = CONFIG_RESET_VAL;
        repeat (4) @(posedge clock);
        check("reset cfg", config_value, CONFIG_RESET_VAL);
        check("reset oe", {6'h00, data_oe, ls_oe}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            wr(ADDR_CONFIG, v & 8'h3f);
            rd(ADDR_CONFIG, cfg);
            wr(7'h01 + 7'(k * 37), v);
            rd(7'h7f - 7'(k), 8'h00);
        end
        v = 8'($random(seed)) & 8'h3f;
        wr(ADDR_CONFIG, v | 8'h80);
        check("soft reset", 8'(pulses), 8'h01);
        rd(ADDR_CONFIG, cfg);
        wr(ADDR_CONFIG, cfg | 8'h40);
        check("released", {7'h00, data_oe}, 8'h00);
        repeat (32) @(posedge clock);
        // Clock enable low freezes the light-source register and the settings
        clk_en <= 1'b0;
        @(posedge clock);
        v = {7'h00, shutter_prev};
        repeat (16) @(posedge clock);
        check("frozen shutter", {7'h00, ls_out}, v);
        check("frozen cfg", config_value, cfg);
        clk_en <= 1'b1;
        @(posedge clock);
        wr(ADDR_CONFIG, (~cfg | 8'h40) & 8'h7f);
        wr(ADDR_CONFIG, ~cfg & 8'h3f);
        // Shortened wake-up wait: this block holds no report logic that needs it
        repeat (2000) @(posedge clock);
        rd(ADDR_CONFIG, cfg);
        finish_test;
    end
endmodule
`default_nettype wire
